// ===== logic/sync_serial.v
// clock-synchronous serial transceiver, one channel, with an AXI4-Lite
// register slave. assumes all pin inputs are synchronous to mclk_i and
// that an external clock is slower than a quarter of mclk_i.
//
// Contract
// - every frame carries exactly eight data bits, one per transfer clock.
// - internal clock is the prescaled clock divided by 2(n+1).
// - divider n is an 8-bit software value, 0 to 255.
// - external clock source: the partner drives the clock pin, device shifts on it.
// - transmit starts on enable, loaded buffer and, if chosen, clear-to-send low.
// - receive starts with receive and transmit enabled and buffer loaded.
// - transmit request on buffer-to-shifter move, or on shift end, by select.
// - receive request when a received frame lands in the receive buffer.
// - overrun flagged when a frame arrives before the previous was read.
// - on overrun the buffer is overwritten and no receive request is raised.
// - software picks rising or falling transfer-clock edge for data.
// - software picks least or most significant bit first.
// - continuous mode: reading the receive buffer re-arms reception at once.
// - channel one may route its clock output to either of two pins.
// - flow control is clear-to-send, request-to-send, or none.
// - synchronous mode exists on channels zero and one only.
// - format bit 7 low gives lsb first, high gives msb first.
// - data output stays high, or floats in open drain, until transfer starts.
// - two-pin clock only with internal clock; it disables flow control.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`include "sync_serial_map.vh"
`timescale 1ns/1ps

module sync_serial (
   input wire mclk_i,
   input wire rstn_i,
   input wire [7:0] awaddr_i,
   input wire awvalid_i,
   output wire awready_o,
   input wire [31:0] wdata_i,
   input wire [3:0] wstrb_i,
   input wire wvalid_i,
   output wire wready_o,
   output wire [1:0] bresp_o,
   output wire bvalid_o,
   input wire bready_i,
   input wire [7:0] araddr_i,
   input wire arvalid_i,
   output wire arready_o,
   output wire [31:0] rdata_o,
   output wire [1:0] rresp_o,
   output wire rvalid_o,
   input wire rready_i,
   input wire clk_pin_i,
   output wire clk_pin_o,
   output wire clk_pin_oe_o,
   output wire clk_alt_o,
   output wire clk_alt_oe_o,
   input wire rxd_i,
   output wire txd_o,
   output wire txd_oe_o,
   input wire cts_n_i,
   output wire rts_n_o,
   output wire tx_irq_o,
   output wire rx_irq_o
);

   localparam ST_IDLE = 1'b0;
   localparam ST_SHIFT = 1'b1;

   // one step of the shifter: new bit enters at the end opposite to output
   function [7:0] shift_in;
      input [7:0] sh;
      input b;
      input msb;
      begin
         shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
      end
   endfunction

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   reg [1:0] rst_sync_ff;
   wire rst_n = rst_sync_ff[1];
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   reg [1:0] bresp_ff, rresp_ff;
   reg [7:0] awaddr_ff;
   reg [31:0] wdata_ff, rdata_ff;
   reg [3:0] wstrb_ff;
   reg [`C_W-1:0] ctrl_ff;
   reg [7:0] brg_ff, txbuf_ff, rxbuf_ff;
   reg tbe_ff, rxf_ff, ore_ff, tir_ff, rir_ff, state_ff;

   wire wr_do = !awready_ff && !wready_ff && !bvalid_ff;
   wire ar_fire = arvalid_i && arready_ff;
   wire wr_ctrl = wr_do && awaddr_ff == `A_CTRL;
   wire wr_brg = wr_do && awaddr_ff == `A_BRG && wstrb_ff[0];
   wire wr_txb = wr_do && awaddr_ff == `A_TXB && wstrb_ff[0];
   wire wr_stat = wr_do && awaddr_ff == `A_STAT && wstrb_ff[0];
   wire rd_rxb = ar_fire && araddr_i == `A_RXB;
   wire wr_map = awaddr_ff == `A_CTRL || awaddr_ff == `A_BRG ||
                 awaddr_ff == `A_TXB || awaddr_ff == `A_RXB ||
                 awaddr_ff == `A_STAT;
   wire [`S_W-1:0] status = {rir_ff, tir_ff, ore_ff, rxf_ff,
                            state_ff == ST_IDLE, tbe_ff};

   reg [31:0] rd_mux;
   reg rd_hit;
   always @* begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (araddr_i)
         `A_CTRL: rd_mux[`C_W-1:0] = ctrl_ff;
         `A_BRG: rd_mux[7:0] = brg_ff;
         `A_TXB: rd_mux[7:0] = txbuf_ff;
         `A_RXB: rd_mux[7:0] = rxbuf_ff;
         `A_STAT: rd_mux[`S_W-1:0] = status;
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= `RESP_OK;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rresp_ff <= `RESP_OK;
         rdata_ff <= 32'h0000_0000;
      end else begin
         if (awvalid_i && awready_ff) begin
            awready_ff <= 1'b0;
            awaddr_ff <= awaddr_i;
         end
         if (wvalid_i && wready_ff) begin
            wready_ff <= 1'b0;
            wdata_ff <= wdata_i;
            wstrb_ff <= wstrb_i;
         end
         if (wr_do) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_map ? `RESP_OK : `RESP_ERR;
         end else if (bvalid_ff && bready_i) begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
         if (ar_fire) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_hit ? `RESP_OK : `RESP_ERR;
         end else if (rvalid_ff && rready_i) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // control and divider registers
   // ------------------------------------------------------------
   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= `CTRL_RST;
         brg_ff <= `BRG_RST;
      end else begin
         if (wr_ctrl && wstrb_ff[0])
            ctrl_ff[`C_LO] <= wdata_ff[7:0];
         if (wr_ctrl && wstrb_ff[1])
            ctrl_ff[`C_HI] <= wdata_ff[13:8];
         if (wr_brg)
            brg_ff <= wdata_ff[7:0];
      end
   end

   wire ext = ctrl_ff[`C_EXT];
   wire pol = ctrl_ff[`C_POL];
   wire msb = ctrl_ff[`C_MSB];
   wire idle_lvl = !pol;
   // two-pin clock needs the internal clock and takes the flow-control pin
   wire mpin = ctrl_ff[`C_MPIN] && !ext;
   wire cts_fn = !ctrl_ff[`C_NOFC] && !ctrl_ff[`C_RTS] && !mpin;
   wire rts_fn = !ctrl_ff[`C_NOFC] && ctrl_ff[`C_RTS] && !mpin;
   wire txen = ctrl_ff[`C_TXEN];
   wire rxen = ctrl_ff[`C_RXEN];

   // ------------------------------------------------------------
   // prescaler and bit-rate divider
   // ------------------------------------------------------------
   reg [4:0] ps_cnt_ff;
   reg [7:0] brg_cnt_ff;
   reg pre_tick;
   always @* begin
      case (ctrl_ff[`C_SRC])
         `SRC_F1: pre_tick = 1'b1;
         `SRC_F8: pre_tick = ps_cnt_ff[2:0] == `PS8_END;
         default: pre_tick = ps_cnt_ff == `PS32_END;
      endcase
   end
   // each half period is n+1 prescaled ticks, full period 2(n+1)
   wire half_tick = state_ff == ST_SHIFT && !ext && pre_tick &&
                    brg_cnt_ff == 8'h00;

   // ------------------------------------------------------------
   // transfer clock edges
   // ------------------------------------------------------------
   reg sclk_ff, pin_q_ff;
   wire int_lead = half_tick && sclk_ff == idle_lvl;
   wire int_trail = half_tick && sclk_ff != idle_lvl;
   wire ext_lead = ext && pin_q_ff == idle_lvl && clk_pin_i != idle_lvl;
   wire ext_trail = ext && pin_q_ff != idle_lvl && clk_pin_i == idle_lvl;
   wire lead = state_ff == ST_SHIFT && (int_lead || ext_lead);
   wire trail = state_ff == ST_SHIFT && (int_trail || ext_trail);

   // ------------------------------------------------------------
   // start condition and shift engine
   // ------------------------------------------------------------
   reg [7:0] sh_ff;
   reg [2:0] bit_cnt_ff;
   reg rx_act_ff, cont_arm_ff, txd_ff;
   reg tx_ev, rx_ev, ore_ev;
   wire cts_ok = !cts_fn || !cts_n_i;
   // the partner keeps an external clock at idle until the frame begins
   wire clk_idle_ok = !ext || clk_pin_i == idle_lvl;
   wire loaded = !tbe_ff || cont_arm_ff;
   wire start = state_ff == ST_IDLE && txen && loaded && cts_ok &&
                clk_idle_ok;
   wire done = trail && bit_cnt_ff == `LAST_BIT;
   wire [7:0] rx_word = shift_in(sh_ff, rxd_i, msb);

   always @* begin
      tx_ev = (start && !tbe_ff && !ctrl_ff[`C_TXIC]) ||
              (done && ctrl_ff[`C_TXIC]);
      ore_ev = done && rx_act_ff && rxf_ff && !rd_rxb;
      rx_ev = done && rx_act_ff && !ore_ev;
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ps_cnt_ff <= 5'h00;
         brg_cnt_ff <= 8'h00;
         state_ff <= ST_IDLE;
         sclk_ff <= 1'b1;
         pin_q_ff <= 1'b1;
         sh_ff <= 8'h00;
         bit_cnt_ff <= 3'h0;
         rx_act_ff <= 1'b0;
         txd_ff <= 1'b1;
      end else begin
         ps_cnt_ff <= ps_cnt_ff + `PS_STEP;
         pin_q_ff <= clk_pin_i;
         if (start) begin
            state_ff <= ST_SHIFT;
            brg_cnt_ff <= brg_ff;
            sclk_ff <= idle_lvl;
            // pure reception still clocks out a word: the dummy one
            sh_ff <= tbe_ff ? `DUMMY : txbuf_ff;
            bit_cnt_ff <= 3'h0;
            rx_act_ff <= rxen;
         end else if (state_ff == ST_SHIFT) begin
            if (pre_tick && !ext)
               brg_cnt_ff <= brg_cnt_ff == 8'h00 ? brg_ff : brg_cnt_ff - 8'h01;
            if (half_tick)
               sclk_ff <= !sclk_ff;
            if (lead)
               txd_ff <= msb ? sh_ff[7] : sh_ff[0];
            if (trail) begin
               sh_ff <= rx_word;
               bit_cnt_ff <= bit_cnt_ff + `BIT_STEP;
            end
            if (done)
               state_ff <= ST_IDLE;
         end else begin
            sclk_ff <= idle_lvl;
         end
      end
   end

   // ------------------------------------------------------------
   // buffers and flags
   // ------------------------------------------------------------
   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         txbuf_ff <= 8'h00;
         rxbuf_ff <= 8'h00;
         tbe_ff <= 1'b1;
         rxf_ff <= 1'b0;
         ore_ff <= 1'b0;
         tir_ff <= 1'b0;
         rir_ff <= 1'b0;
         cont_arm_ff <= 1'b0;
      end else begin
         // a write in the same cycle as the move keeps the new data pending
         if (wr_txb) begin
            txbuf_ff <= wdata_ff[7:0];
            tbe_ff <= 1'b0;
         end else if (start) begin
            tbe_ff <= 1'b1;
         end
         if (done && rx_act_ff)
            rxbuf_ff <= rx_word;
         if (done && rx_act_ff)
            rxf_ff <= 1'b1;
         else if (rd_rxb)
            rxf_ff <= 1'b0;
         if (start)
            cont_arm_ff <= 1'b0;
         else if (rd_rxb && ctrl_ff[`C_CONT] && rxen)
            cont_arm_ff <= 1'b1;
         if (ore_ev)
            ore_ff <= 1'b1;
         else if (wr_stat && wdata_ff[`S_ORE])
            ore_ff <= 1'b0;
         if (tx_ev)
            tir_ff <= 1'b1;
         else if (wr_stat && wdata_ff[`S_TIR])
            tir_ff <= 1'b0;
         if (rx_ev)
            rir_ff <= 1'b1;
         else if (wr_stat && wdata_ff[`S_RIR])
            rir_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // registered pin outputs
   // ------------------------------------------------------------
   reg clk_pin_ff, clk_pin_oe_ff, clk_alt_ff, clk_alt_oe_ff;
   reg txd_out_ff, txd_oe_ff, rts_n_ff, tx_irq_ff, rx_irq_ff;
   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         clk_pin_ff <= 1'b1;
         clk_pin_oe_ff <= 1'b0;
         clk_alt_ff <= 1'b1;
         clk_alt_oe_ff <= 1'b0;
         txd_out_ff <= 1'b1;
         txd_oe_ff <= 1'b0;
         rts_n_ff <= 1'b1;
         tx_irq_ff <= 1'b0;
         rx_irq_ff <= 1'b0;
      end else begin
         clk_pin_ff <= sclk_ff;
         clk_alt_ff <= sclk_ff;
         // the unselected pin is released rather than held at idle
         clk_pin_oe_ff <= !ext && !(mpin && ctrl_ff[`C_PSEL]);
         clk_alt_oe_ff <= mpin && ctrl_ff[`C_PSEL];
         txd_out_ff <= txd_ff;
         txd_oe_ff <= ctrl_ff[`C_OD] ? !txd_ff : 1'b1;
         rts_n_ff <= rts_fn ? !(rxen && !rxf_ff) : 1'b1;
         tx_irq_ff <= tx_ev;
         rx_irq_ff <= rx_ev;
      end
   end

   assign awready_o = awready_ff;
   assign wready_o = wready_ff;
   assign bresp_o = bresp_ff;
   assign bvalid_o = bvalid_ff;
   assign arready_o = arready_ff;
   assign rdata_o = rdata_ff;
   assign rresp_o = rresp_ff;
   assign rvalid_o = rvalid_ff;
   assign clk_pin_o = clk_pin_ff;
   assign clk_pin_oe_o = clk_pin_oe_ff;
   assign clk_alt_o = clk_alt_ff;
   assign clk_alt_oe_o = clk_alt_oe_ff;
   assign txd_o = txd_out_ff;
   assign txd_oe_o = txd_oe_ff;
   assign rts_n_o = rts_n_ff;
   assign tx_irq_o = tx_irq_ff;
   assign rx_irq_o = rx_irq_ff;

   // channel two has no synchronous mode, so this module models channels
   // zero and one only; the two-pin clock is simply left unused on zero

endmodule // sync_serial

// ===== shared/sync_serial_map.vh
// constants of the clock-synchronous serial transceiver: register offsets,
// control and status bit positions, reset values and shift-engine counts.
// assumes inclusion by logic/sync_serial.v and by the testbench; definitions only.
`ifndef SYNC_SERIAL_MAP_VH
`define SYNC_SERIAL_MAP_VH

// ------------------------------------------------------------
// register byte offsets (low address byte)
// ------------------------------------------------------------
`define A_CTRL 8'h00
`define A_BRG 8'h04
`define A_TXB 8'h08
`define A_RXB 8'h0C
`define A_STAT 8'h10

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define C_SRC 1:0
`define C_RTS 2
`define C_EXT 3
`define C_NOFC 4
`define C_OD 5
`define C_POL 6
`define C_MSB 7
`define C_TXIC 8
`define C_CONT 9
`define C_MPIN 10
`define C_PSEL 11
`define C_TXEN 12
`define C_RXEN 13
`define C_W 14
`define C_LO 7:0
`define C_HI 13:8
`define CTRL_RST 14'h0000
`define BRG_RST 8'h00

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define S_TBE 0
`define S_TSE 1
`define S_RXF 2
`define S_ORE 3
`define S_TIR 4
`define S_RIR 5
`define S_W 6

// ------------------------------------------------------------
// prescaler, shift engine and slave response codes
// ------------------------------------------------------------
`define SRC_F1 2'h0
`define SRC_F8 2'h1
`define PS8_END 3'h7
`define PS32_END 5'h1F
`define PS_STEP 5'h01
`define LAST_BIT 3'h7
`define BIT_STEP 3'h1
`define DUMMY 8'hFF
`define RESP_OK 2'h0
`define RESP_ERR 2'h2

`endif

// ===== verification/sync_serial_sva.sv
// assertions on the register slave handshake and the serial pin timing.
// assumes a bind into sync_serial; every signal lives in the mclk_i domain.
`timescale 1ns/1ps
module sync_serial_sva (
   input wire mclk_i,
   input wire rstn_i,
   input wire awvalid_i,
   input wire awready_o,
   input wire wvalid_i,
   input wire wready_o,
   input wire [1:0] bresp_o,
   input wire bvalid_o,
   input wire bready_i,
   input wire arvalid_i,
   input wire arready_o,
   input wire [31:0] rdata_o,
   input wire rvalid_o,
   input wire rready_i,
   input wire clk_pin_o,
   input wire clk_pin_oe_o,
   input wire clk_alt_oe_o,
   input wire txd_o,
   input wire tx_irq_o,
   input wire rx_irq_o
);
   default clocking dc @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   // the write lands one edge after both halves are taken, the answer shows one edge later
   AST_WR_ANSWER: assert property (awvalid_i && awready_o && wvalid_i && wready_o |-> ##2 bvalid_o)
      else $error("write answer missing");
   AST_WR_HOLD: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
      else $error("write answer dropped early");
   AST_WR_REFUSE: assert property (bvalid_o |-> !awready_o && !wready_o)
      else $error("write accepted while answer pending");
   AST_RD_ANSWER: assert property (arvalid_i && arready_o |=> rvalid_o && !arready_o)
      else $error("read answer missing");
   AST_RD_HOLD: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
      else $error("read answer dropped early");
   AST_TX_PULSE: assert property (tx_irq_o |=> !tx_irq_o)
      else $error("transmit request longer than one cycle");
   AST_RX_PULSE: assert property (rx_irq_o |-> !$past(rx_irq_o))
      else $error("receive request longer than one cycle");
   AST_ONE_CLK_PIN: assert property (!(clk_pin_oe_o && clk_alt_oe_o))
      else $error("both clock pins driven");
   // data may only move together with a clock edge on the pin
   AST_TXD_HOLD: assert property (clk_pin_oe_o && $stable({clk_pin_o, clk_pin_oe_o}) |-> $stable(txd_o))
      else $error("data changed without a clock edge");
   cover property (rx_irq_o);
   cover property (tx_irq_o);
   cover property (bvalid_o && bready_i && bresp_o == 2'h2);
endmodule // sync_serial_sva

bind sync_serial sync_serial_sva chk_u (.mclk_i, .rstn_i, .awvalid_i, .awready_o, .wvalid_i,
   .wready_o, .bresp_o, .bvalid_o, .bready_i, .arvalid_i, .arready_o, .rdata_o, .rvalid_o,
   .rready_i, .clk_pin_o, .clk_pin_oe_o, .clk_alt_oe_o, .txd_o, .tx_irq_o, .rx_irq_o);

// ===== verification/sync_serial_peer.sv
// behavioural far-side device: slave on the device clock, master after go_i.
// assumes a pulled-up clock line and that mclk_i is the bench clock.
`timescale 1ns/1ps
module sync_serial_peer (
   input wire mclk_i,
   input wire pol_i,
   input wire go_i,
   input wire load_i,
   input wire [7:0] tx_byte_i,
   input wire sclk_i,
   input wire txd_i,
   output reg sclk_o,
   output reg sclk_oe_o,
   output reg rxd_o = 1'b1,
   output reg [7:0] rx_byte_o = 8'h00
);
   reg last_ff = 1'b1;
   reg [7:0] sh_ff = 8'h00;
   reg [3:0] n_ff = 4'h0;
   always @(posedge mclk_i) begin
      last_ff <= sclk_i;
      if (load_i) begin
         sh_ff <= tx_byte_i;
         n_ff <= 4'h0;
      end else if (sclk_i != last_ff && sclk_i == pol_i) begin
         rxd_o <= sh_ff[7];
         sh_ff <= {sh_ff[6:0], 1'b0};
      end else if (sclk_i != last_ff) begin
         rx_byte_o <= {rx_byte_o[6:0], txd_i};
         n_ff <= n_ff + 4'h1;
         // hold time over: flip so a stale bit is never taken as valid
         if (n_ff == 4'h7) rxd_o <= ~rxd_o;
      end
   end
   initial begin
      sclk_o = 1'b1;
      sclk_oe_o = 1'b0;
      forever begin
         @(posedge mclk_i);
         if (go_i) begin
            sclk_o <= ~pol_i;
            sclk_oe_o <= 1'b1;
            repeat (8) @(posedge mclk_i);
            repeat (16) begin
               sclk_o <= ~sclk_o;
               repeat (4) @(posedge mclk_i);
            end
            sclk_oe_o <= 1'b0;
         end
      end
   end
endmodule // sync_serial_peer

// ===== verification/sync_serial_tb.sv
// self-checking bench: register accesses on the slave bus, frames through the peer.
// assumes clock and data lines are pulled up when nobody drives them.
`timescale 1ns/1ps
`include "sync_serial_map.vh"
module sync_serial_tb;
   reg mclk_i, rstn_i, awv, wv, brdy, arv, rrdy, cts_n, pol, go, load, lastc;
   reg [7:0] awa, ara, pbyte, t, p;
   reg [31:0] wd;
   int n_mismatch = 0, n_checks = 0, n_tx = 0, n_rx = 0, gap = 0, cnt = 0, b;
   wire awr, wrdy, bv, arr, rvl, txd, txd_oe, clk_o, clk_oe, alt, alt_oe, rts_n, tx_irq, rx_irq;
   wire p_clk, p_oe, p_rxd;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] pgot;
   wire sclk = clk_oe ? clk_o : (p_oe ? p_clk : 1'b1);
   wire sdo = txd_oe ? txd : 1'b1;
   logic [7:0] nt [4] = '{8'hFF, 8'h03, 8'h00, 8'h01};
   sync_serial dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .awaddr_i(awa), .awvalid_i(awv),
      .awready_o(awr), .wdata_i(wd), .wstrb_i(4'hF), .wvalid_i(wv), .wready_o(wrdy),
      .bresp_o(bresp), .bvalid_o(bv), .bready_i(brdy), .araddr_i(ara), .arvalid_i(arv),
      .arready_o(arr), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvl), .rready_i(rrdy),
      .clk_pin_i(sclk), .clk_pin_o(clk_o), .clk_pin_oe_o(clk_oe), .clk_alt_o(alt),
      .clk_alt_oe_o(alt_oe), .rxd_i(p_rxd), .txd_o(txd), .txd_oe_o(txd_oe), .cts_n_i(cts_n),
      .rts_n_o(rts_n), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
   sync_serial_peer peer_u (.mclk_i(mclk_i), .pol_i(pol), .go_i(go), .load_i(load),
      .tx_byte_i(pbyte), .sclk_i(sclk), .txd_i(sdo), .sclk_o(p_clk), .sclk_oe_o(p_oe),
      .rxd_o(p_rxd), .rx_byte_o(pgot));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // gap holds the last half period seen on the clock line, in mclk cycles
   always @(posedge mclk_i) begin
      lastc <= sclk;
      cnt <= (sclk != lastc) ? 1 : cnt + 1;
      if (sclk != lastc) gap <= cnt;
      if (tx_irq === 1'b1) n_tx <= n_tx + 1;
      if (rx_irq === 1'b1) n_rx <= n_rx + 1;
   end
   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int k = 0; k < 8; k++) rev[k] = v[7 - k];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // the slave answers when it likes; only the watchdog bounds these waits
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      @(posedge mclk_i);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      forever begin
         @(posedge mclk_i);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
         if (bv) break;
      end
      brdy <= 1'b0;
      chk(bresp, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
         input logic [1:0] r = 2'h0);
      @(posedge mclk_i);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      forever begin
         @(posedge mclk_i);
         if (arr) arv <= 1'b0;
         if (rvl) break;
      end
      rrdy <= 1'b0;
      chk(rdata & m, e);
      chk(rresp, r);
   endtask
   task automatic ld(input logic [7:0] pd);
      @(posedge mclk_i);
      pbyte <= pd;
      load <= 1'b1;
      @(posedge mclk_i);
      load <= 1'b0;
   endtask
   // completion is the transmit request: shift end when cause select picks it, else the buffer move
   task automatic frame(input logic [7:0] td, input logic [7:0] pd, input logic g = 1'b0);
      int base;
      base = n_tx;
      ld(pd);
      wr(`A_TXB, {24'h0, td});
      if (g) begin
         go <= 1'b1;
         @(posedge mclk_i);
         go <= 1'b0;
      end
      while (n_tx == base) @(posedge mclk_i);
      wt(4);
   endtask
   task report_and_stop;
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      {rstn_i, awv, wv, brdy, arv, rrdy, pol, go, load, lastc, cts_n} = 11'h003;
      {awa, ara, pbyte, wd} = 56'h0;
      wt(4);
      rstn_i <= 1'b1;
      wt(3);
      rd(`A_CTRL, 32'h0);
      rd(`A_STAT, 32'h3, 32'h3F);
      rd(8'h14, 32'h0, 32'hFFFFFFFF, `RESP_ERR);
      wr(8'h14, 32'h0, `RESP_ERR);
      wr(`A_CTRL, 32'h1110);
      chk(sdo, 1);
      frame(8'hA5, 8'h00);
      chk(pgot, rev(8'hA5));
      chk(gap, 1);
      chk(n_rx, 0);
      for (int i = 0; i < 4; i++) begin
         t = 8'h96 + 8'h21 * i[7:0];
         p = 8'hC5 - 8'h13 * i[7:0];
         pol <= i[0];
         wr(`A_BRG, {24'h0, nt[i]});
         wr(`A_CTRL, 32'h3110 + i + 64 * (i % 2) + 128 * (i / 2));
         frame(t, p);
         chk(pgot, i[1] ? t : rev(t));
         rd(`A_RXB, i[1] ? p : rev(p), 32'hFF);
         chk(n_rx, i + 1);
         chk(gap, (nt[i] + 1) * (i == 0 ? 1 : i == 1 ? 8 : 32));
      end
      pol <= 1'b0;
      wr(`A_BRG, 32'h3);
      wr(`A_CTRL, 32'h3110);
      frame(8'h11, 8'h81);
      frame(8'h22, 8'h42);
      chk(n_rx, 5);
      rd(`A_STAT, 32'h8, 32'h8);
      rd(`A_RXB, rev(8'h42), 32'hFF);
      wr(`A_STAT, 32'h8);
      rd(`A_STAT, 32'h0, 32'h8);
      wr(`A_CTRL, 32'h3310);
      frame(8'h33, 8'h0F);
      ld(8'hF0);
      b = n_rx;
      rd(`A_RXB, rev(8'h0F), 32'hFF);
      while (n_rx == b) @(posedge mclk_i);
      wt(4);
      wr(`A_CTRL, 32'h3110);
      chk(pgot, 8'hFF);
      rd(`A_RXB, rev(8'hF0), 32'hFF);
      wr(`A_CTRL, 32'h3118);
      frame(8'hB7, 8'h6C, 1'b1);
      chk(pgot, rev(8'hB7));
      rd(`A_RXB, rev(8'h6C), 32'hFF);
      chk(clk_oe, 0);
      wr(`A_CTRL, 32'h1010);
      frame(8'h7E, 8'h00);
      rd(`A_STAT, 32'h1, 32'h3);
      wt(80);
      wr(`A_CTRL, 32'h1100);
      b = n_tx;
      wr(`A_TXB, 32'h44);
      wt(100);
      chk(n_tx, b);
      rd(`A_STAT, 32'h0, 32'h1);
      cts_n <= 1'b0;
      while (n_tx == b) @(posedge mclk_i);
      wt(4);
      wr(`A_CTRL, 32'h3104);
      wt(2);
      chk(rts_n, 0);
      wr(`A_CTRL, 32'h1D10);
      frame(8'h5C, 8'h00);
      chk(alt_oe, 1);
      chk(clk_oe, 0);
      report_and_stop;
   end
   // about five times the longest expected run
   initial begin
      wt(40000);
      n_mismatch++;
      report_and_stop;
   end
endmodule // sync_serial_tb
